// ==== core/sds_defines.svh ====
// Constants for the shutdown sequencer and power-on reset
`ifndef SDS_DEFINES_SVH
`define SDS_DEFINES_SVH

// Clock and timebase
`define SDS_CLK_PERIOD_NS 10
`define SDS_TICK_NS 62500
`define SDS_TICK_CYCLES (`SDS_TICK_NS / `SDS_CLK_PERIOD_NS)
`define SDS_DELAY_BIAS 8
`define SDS_POR_MIN_NS 9500
`define SDS_POR_CYCLES ((`SDS_POR_MIN_NS + `SDS_CLK_PERIOD_NS - 1) / `SDS_CLK_PERIOD_NS)

// Table and bank sizes
`define SDS_NSTEP 40
`define SDS_NREG 11

// Register indices, byte address is four times the index
`define SDS_R_BIAS 8'h04
`define SDS_R_MIDRAIL 8'h05
`define SDS_R_PHONES_PGA 8'h0E
`define SDS_R_LINE_PGA 8'h0F
`define SDS_R_CONV 8'h12
`define SDS_R_CLOCKS 8'h16
`define SDS_R_SERVO_EN 8'h43
`define SDS_R_SERVO_TRIG 8'h44
`define SDS_R_PHONES 8'h5A
`define SDS_R_LINE 8'h5E
`define SDS_R_PUMP 8'h62
`define SDS_R_DUMMY 8'hFF
`define SDS_R_SEQ_CTRL 8'h6C
`define SDS_R_SEQ_ADDR 8'h6D
`define SDS_R_SEQ_DATA 8'h6E
`define SDS_R_SEQ_LAUNCH 8'h6F
`define SDS_R_SEQ_STATUS 8'h70

// Field positions
`define SDS_CTRL_ENA_BIT 8
`define SDS_LAUNCH_START_BIT 8
`define SDS_LAUNCH_ABORT_BIT 9
`define SDS_SADDR_START_LSB 8
`define SDS_SADDR_WIDTH_LSB 12
`define SDS_SDATA_DELAY_LSB 8
`define SDS_SDATA_EOS_BIT 14
`define SDS_STAT_BUSY_BIT 0
`define SDS_STAT_CAL_BIT 1
`define SDS_STAT_IDX_LSB 8

// Launch values
`define SDS_LAUNCH_SHUTDOWN 16'h0119
`define SDS_SHUTDOWN_INDEX 6'h19

`endif

// ==== core/sds_pkg.sv ====
// Types for the shutdown sequencer and power-on reset
`include "sds_defines.svh"
package sds_pkg;
  typedef enum logic [1:0] {SDS_IDLE, SDS_WRITE, SDS_WAIT} sds_fsm_t;

  // One sequencer step
  typedef struct packed {
    logic [7:0] addr;
    logic [2:0] width_m1;
    logic [3:0] start;
    logic [7:0] data;
    logic [3:0] delay;
    logic end_of_sequence_flag;
  } sds_step_t;

  // Analog enables taken from the register bank, and the calibration valid flag
  typedef struct packed {
    logic [7:0] phones_ctrl;
    logic [7:0] line_ctrl;
    logic [3:0] offset_servo_channel_enable;
    logic charge_pump_enable;
    logic left_converter_enable;
    logic right_converter_enable;
    logic processing_clock_enable;
    logic [1:0] phones_gain_amp_enable;
    logic [1:0] line_gain_amp_enable;
    logic bias_enable;
    logic midrail_reference_enable;
    logic midrail_buffer_enable;
    logic [1:0] midrail_resistor_select;
    logic offset_cal_valid;
  } sds_power_t;

  // Whole state of the sequencer top
  typedef struct packed {
    sds_fsm_t fsm;
    logic [5:0] idx;
    logic busy;
    logic [12:0] wait_cnt;
    logic [15:0] tick_cnt;
    logic seq_ena;
    logic [5:0] wr_idx;
    logic cal_valid;
    logic [`SDS_NREG-1:0][15:0] bank;
    sds_step_t [`SDS_NSTEP-1:0] steps;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sds_state_t;

  // Whole state of the reset timer
  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [9:0] cnt;
    logic ok;
  } sds_por_state_t;
endpackage : sds_pkg

// ==== core/sds_por_timer.sv ====
// Power-on reset timer with supply synchronisers
`timescale 1ns/1ns
`default_nettype none
`include "sds_defines.svh"
module sds_por_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Supply monitors, asynchronous
  input wire logic analog_supply_ok,
  input wire logic core_supply_ok,
  // Reset released
  output logic por_ok
);
  import sds_pkg::*;

  localparam logic [9:0] POR_LAST = 10'(`SDS_POR_CYCLES - 1);

  sds_por_state_t q;
  sds_por_state_t d;

  // Synchronise, then hold reset for the minimum period
  always_comb
  begin
    d = q;
    d.sync1 = {analog_supply_ok, core_supply_ok};
    d.sync2 = q.sync1;
    if (!(&q.sync2))
    begin
      d.cnt = 10'h000;
      d.ok = 1'b0;
    end
    else if (!q.ok)
    begin
      if (q.cnt == POR_LAST)
        d.ok = 1'b1;
      else
        d.cnt = q.cnt + 10'h001;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  assign por_ok = q.ok;

  property p_por_min;
    @(posedge pclk) disable iff (!presetn) $rose(q.ok) |-> $past(q.cnt) == POR_LAST;
  endproperty
  a_por_min: assert property (p_por_min) else $error("reset released before minimum period");

  property p_por_drop;
    @(posedge pclk) disable iff (!presetn) !(&q.sync2) |=> !q.ok;
  endproperty
  a_por_drop: assert property (p_por_drop) else $error("reset not held while supply low");

endmodule : sds_por_timer
`default_nettype wire

// ==== core/sds_top.sv ====
// Control write sequencer with default shutdown, bank and reset
// How it works
// - Writing 0119h to launch starts step 25
// - Delay timebase derived from clock, run ~296ms
// - Step 25 line short removal off, 0.5625ms
// - Step 26 phones short removal off
// - Step 27 clears phones enables
// - Step 28 clears line output enables
// - Step 29 disables all offset servo channels
// - Step 30 switches charge pump off
// - Step 31 disables both converters
// - Step 32 stops processing clock
// - Step 33 disables phones gain amps
// - Step 34 disables line gain amps
// - Step 35 clears bias enable
// - Step 36 midrail reference off, 256.5ms wait
// - Step 37 repeats, 32.5ms wait
// - During power-on reset hold logic, drop writes
// - After reset defaults, writes accepted
// - Power-on reset lasts at least 9.5us
// - Default start-up sets up 48kHz playback
// - Offset calibration kept until power loss
// - Busy flag high while sequence runs
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "sds_defines.svh"
module sds_top #(
  parameter int unsigned TICK_CYCLES = `SDS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Supply monitors
  input wire logic analog_supply_ok,
  input wire logic core_supply_ok,
  // Status and analog enables
  output logic sequencer_busy_flag,
  output logic por_released,
  output sds_pkg::sds_power_t power_ctrl
);
  import sds_pkg::*;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
  localparam logic [5:0] LAST_STEP = 6'(`SDS_NSTEP - 1);
  localparam int SLOT_BIAS = 0;
  localparam int SLOT_MID = 1;
  localparam int SLOT_HPGA = 2;
  localparam int SLOT_LPGA = 3;
  localparam int SLOT_CONV = 4;
  localparam int SLOT_CLK = 5;
  localparam int SLOT_SERVO = 6;
  localparam int SLOT_TRIG = 7;
  localparam int SLOT_PHONES = 8;
  localparam int SLOT_LINE = 9;
  localparam int SLOT_PUMP = 10;

  // Bank slot addresses
  localparam logic [7:0] BANK_ADDR [`SDS_NREG] = '{
    `SDS_R_BIAS, `SDS_R_MIDRAIL, `SDS_R_PHONES_PGA, `SDS_R_LINE_PGA, `SDS_R_CONV, `SDS_R_CLOCKS,
    `SDS_R_SERVO_EN, `SDS_R_SERVO_TRIG, `SDS_R_PHONES, `SDS_R_LINE, `SDS_R_PUMP};

  // Default step table: start-up 0..24, shutdown 25..39
  localparam sds_step_t DEFAULT_STEPS [`SDS_NSTEP] = '{
    '{`SDS_R_BIAS, 3'h4, 4'h0, 8'h1A, 4'h0, 1'b0},
    '{`SDS_R_MIDRAIL, 3'h7, 4'h0, 8'h47, 4'h6, 1'b0},
    '{`SDS_R_MIDRAIL, 3'h1, 4'h1, 8'h01, 4'h0, 1'b0},
    '{`SDS_R_BIAS, 3'h0, 4'h0, 8'h01, 4'h0, 1'b0},
    '{`SDS_R_PHONES_PGA, 3'h1, 4'h0, 8'h03, 4'h0, 1'b0},
    '{`SDS_R_LINE_PGA, 3'h1, 4'h0, 8'h03, 4'h0, 1'b0},
    '{`SDS_R_CLOCKS, 3'h0, 4'h1, 8'h01, 4'h0, 1'b0},
    '{`SDS_R_CONV, 3'h1, 4'h2, 8'h03, 4'h5, 1'b0},
    '{`SDS_R_DUMMY, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0},
    '{`SDS_R_BIAS, 3'h0, 4'h4, 8'h00, 4'h0, 1'b0},
    '{`SDS_R_PUMP, 3'h0, 4'h0, 8'h01, 4'h6, 1'b0},
    '{`SDS_R_DUMMY, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0},
    '{`SDS_R_PHONES, 3'h7, 4'h0, 8'h11, 4'h0, 1'b0},
    '{`SDS_R_LINE, 3'h7, 4'h0, 8'h11, 4'h0, 1'b0},
    '{`SDS_R_PHONES, 3'h7, 4'h0, 8'h33, 4'h0, 1'b0},
    '{`SDS_R_LINE, 3'h7, 4'h0, 8'h33, 4'h0, 1'b0},
    '{`SDS_R_SERVO_EN, 3'h3, 4'h0, 8'h0F, 4'hC, 1'b0},
    '{`SDS_R_SERVO_TRIG, 3'h7, 4'h0, 8'hF0, 4'h0, 1'b0},
    '{`SDS_R_DUMMY, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0},
    '{`SDS_R_PHONES, 3'h7, 4'h0, 8'h77, 4'h0, 1'b0},
    '{`SDS_R_LINE, 3'h7, 4'h0, 8'h77, 4'h0, 1'b0},
    '{`SDS_R_PHONES, 3'h7, 4'h0, 8'hFF, 4'h0, 1'b0},
    '{`SDS_R_LINE, 3'h7, 4'h0, 8'hFF, 4'h0, 1'b1},
    '{`SDS_R_DUMMY, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0},
    '{`SDS_R_DUMMY, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0},
    '{`SDS_R_LINE, 3'h7, 4'h0, 8'h77, 4'h0, 1'b0},
    '{`SDS_R_PHONES, 3'h7, 4'h0, 8'h77, 4'h0, 1'b0},
    '{`SDS_R_PHONES, 3'h7, 4'h0, 8'h00, 4'h0, 1'b0},
    '{`SDS_R_LINE, 3'h7, 4'h0, 8'h00, 4'h0, 1'b0},
    '{`SDS_R_SERVO_EN, 3'h3, 4'h0, 8'h00, 4'h0, 1'b0},
    '{`SDS_R_PUMP, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0},
    '{`SDS_R_CONV, 3'h1, 4'h2, 8'h00, 4'h0, 1'b0},
    '{`SDS_R_CLOCKS, 3'h0, 4'h1, 8'h00, 4'h0, 1'b0},
    '{`SDS_R_PHONES_PGA, 3'h1, 4'h0, 8'h00, 4'h0, 1'b0},
    '{`SDS_R_LINE_PGA, 3'h1, 4'h0, 8'h00, 4'h0, 1'b0},
    '{`SDS_R_BIAS, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0},
    '{`SDS_R_MIDRAIL, 3'h0, 4'h0, 8'h00, 4'hC, 1'b0},
    '{`SDS_R_MIDRAIL, 3'h0, 4'h0, 8'h00, 4'h9, 1'b0},
    '{`SDS_R_MIDRAIL, 3'h7, 4'h0, 8'h00, 4'h0, 1'b0},
    '{`SDS_R_BIAS, 3'h1, 4'h0, 8'h00, 4'h0, 1'b1}};

  // Reset image of the whole state
  function automatic sds_state_t init_state();
    sds_state_t s;
    s = '0;
    s.fsm = SDS_IDLE;
    for (int i = 0; i < `SDS_NSTEP; i++)
      s.steps[i] = DEFAULT_STEPS[i];
    return s;
  endfunction : init_state

  localparam sds_state_t RST = init_state();

  sds_state_t q;
  sds_state_t d;
  sds_step_t cur;
  logic por_ok;
  logic tick;
  logic apb_wr;
  logic host_hit;
  logic [3:0] host_slot;
  logic seq_hit;
  logic [3:0] seq_slot;
  logic [7:0] ridx;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic [31:0] rd;
  logic rd_err;
  logic keep_ready;
  logic keep_err;
  logic [31:0] keep_data;

  // Reset period and supply synchronisers
  sds_por_timer u_por (
    .pclk(pclk),
    .presetn(presetn),
    .analog_supply_ok(analog_supply_ok),
    .core_supply_ok(core_supply_ok),
    .por_ok(por_ok)
  );

  // Next-state logic
  always_comb
  begin
    d = q;
    ridx = paddr[9:2];
    // Delay timebase of 62.5us ticks
    tick = (q.tick_cnt == TICK_LAST);
    d.tick_cnt = tick ? 16'h0000 : q.tick_cnt + 16'h0001;
    cur = (q.idx <= LAST_STEP) ? q.steps[q.idx] : '0;
    wmask = 16'(((32'h0000_0001 << (32'(cur.width_m1) + 32'h0000_0001)) - 32'h0000_0001) << cur.start);
    wval = 16'({24'h00_0000, cur.data} << cur.start) & wmask;
    // Slot lookup for host and sequencer
    host_hit = 1'b0;
    host_slot = 4'h0;
    seq_hit = 1'b0;
    seq_slot = 4'h0;
    for (int i = 0; i < `SDS_NREG; i++)
    begin
      if (ridx == BANK_ADDR[i])
      begin
        host_hit = 1'b1;
        host_slot = 4'(i);
      end
      if (cur.addr == BANK_ADDR[i])
      begin
        seq_hit = 1'b1;
        seq_slot = 4'(i);
      end
    end
    // APB setup phase: answer in the next cycle
    d.pready = psel & ~penable;
    rd = 32'h0000_0000;
    rd_err = 1'b0;
    if (host_hit)
      rd = {16'h0000, q.bank[host_slot]};
    else
    begin
      case (ridx)
        `SDS_R_SEQ_CTRL: rd = 32'({q.seq_ena, 2'b00, q.wr_idx});
        `SDS_R_SEQ_ADDR: rd = 32'({q.steps[q.wr_idx].width_m1, q.steps[q.wr_idx].start, q.steps[q.wr_idx].addr});
        `SDS_R_SEQ_DATA: rd = 32'({q.steps[q.wr_idx].end_of_sequence_flag, 2'b00, q.steps[q.wr_idx].delay, q.steps[q.wr_idx].data});
        `SDS_R_SEQ_LAUNCH: rd = 32'h0000_0000;
        `SDS_R_SEQ_STATUS: rd = 32'({q.idx, 6'h00, q.cal_valid, q.busy});
        `SDS_R_DUMMY: rd = 32'h0000_0000;
        default: rd_err = 1'b1;
      endcase
    end
    if (psel && !penable)
    begin
      d.prdata = rd;
      d.pslverr = rd_err | ~por_ok;
    end
    // APB access edge commits a write
    apb_wr = psel & penable & q.pready & pwrite & ~q.pslverr;
    if (apb_wr)
    begin
      if (host_hit)
        d.bank[host_slot] = pwdata[15:0];
      case (ridx)
        `SDS_R_SEQ_CTRL:
        begin
          d.seq_ena = pwdata[`SDS_CTRL_ENA_BIT];
          d.wr_idx = pwdata[5:0];
        end
        `SDS_R_SEQ_ADDR:
        begin
          if (q.seq_ena && q.wr_idx <= LAST_STEP)
          begin
            d.steps[q.wr_idx].addr = pwdata[7:0];
            d.steps[q.wr_idx].start = pwdata[`SDS_SADDR_START_LSB +: 4];
            d.steps[q.wr_idx].width_m1 = pwdata[`SDS_SADDR_WIDTH_LSB +: 3];
          end
        end
        `SDS_R_SEQ_DATA:
        begin
          if (q.seq_ena && q.wr_idx <= LAST_STEP)
          begin
            d.steps[q.wr_idx].data = pwdata[7:0];
            d.steps[q.wr_idx].delay = pwdata[`SDS_SDATA_DELAY_LSB +: 4];
            d.steps[q.wr_idx].end_of_sequence_flag = pwdata[`SDS_SDATA_EOS_BIT];
          end
        end
        default:
        begin
        end
      endcase
    end
    // Sequencer: masked write, then coded wait
    unique case (q.fsm)
      SDS_IDLE:
      begin
      end
      SDS_WRITE:
      begin
        if (seq_hit)
          d.bank[seq_slot] = (d.bank[seq_slot] & ~wmask) | wval;
        // Calibration result stays until power-on reset
        if (cur.addr == `SDS_R_SERVO_TRIG && wval != 16'h0000)
          d.cal_valid = 1'b1;
        if (cur.end_of_sequence_flag || q.idx >= LAST_STEP)
        begin
          d.fsm = SDS_IDLE;
          d.busy = 1'b0;
        end
        else
        begin
          d.fsm = SDS_WAIT;
          d.wait_cnt = 13'((32'h0000_0001 << cur.delay) + `SDS_DELAY_BIAS);
        end
      end
      SDS_WAIT:
      begin
        if (tick)
        begin
          if (q.wait_cnt == 13'h0001)
          begin
            d.fsm = SDS_WRITE;
            d.idx = q.idx + 6'h01;
          end
          else
            d.wait_cnt = q.wait_cnt - 13'h0001;
        end
      end
      default:
      begin
        d.fsm = SDS_IDLE;
        d.busy = 1'b0;
      end
    endcase
    // Launch or abort
    if (apb_wr && ridx == `SDS_R_SEQ_LAUNCH)
    begin
      if (pwdata[`SDS_LAUNCH_ABORT_BIT])
      begin
        d.fsm = SDS_IDLE;
        d.busy = 1'b0;
      end
      else if (pwdata[`SDS_LAUNCH_START_BIT] && q.fsm == SDS_IDLE && pwdata[5:0] <= LAST_STEP)
      begin
        d.idx = pwdata[5:0];
        d.busy = 1'b1;
        d.fsm = SDS_WRITE;
      end
    end
    // Power-on reset holds everything but the bus answer
    keep_ready = d.pready;
    keep_err = d.pslverr;
    keep_data = d.prdata;
    if (!por_ok)
    begin
      d = RST;
      d.pready = keep_ready;
      d.pslverr = keep_err;
      d.prdata = keep_data;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= RST;
    else
      q <= d;
  end

  // Outputs straight from state
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign sequencer_busy_flag = q.busy;
  assign por_released = por_ok;
  assign power_ctrl.phones_ctrl = q.bank[SLOT_PHONES][7:0];
  assign power_ctrl.line_ctrl = q.bank[SLOT_LINE][7:0];
  assign power_ctrl.offset_servo_channel_enable = q.bank[SLOT_SERVO][3:0];
  assign power_ctrl.charge_pump_enable = q.bank[SLOT_PUMP][0];
  assign power_ctrl.left_converter_enable = q.bank[SLOT_CONV][3];
  assign power_ctrl.right_converter_enable = q.bank[SLOT_CONV][2];
  assign power_ctrl.processing_clock_enable = q.bank[SLOT_CLK][1];
  assign power_ctrl.phones_gain_amp_enable = q.bank[SLOT_HPGA][1:0];
  assign power_ctrl.line_gain_amp_enable = q.bank[SLOT_LPGA][1:0];
  assign power_ctrl.bias_enable = q.bank[SLOT_BIAS][0];
  assign power_ctrl.midrail_reference_enable = q.bank[SLOT_MID][0];
  assign power_ctrl.midrail_buffer_enable = q.bank[SLOT_MID][6];
  assign power_ctrl.midrail_resistor_select = q.bank[SLOT_MID][2:1];
  assign power_ctrl.offset_cal_valid = q.cal_valid;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !por_ok);

  property p_launch;
    apb_wr && ridx == `SDS_R_SEQ_LAUNCH && pwdata[15:0] == `SDS_LAUNCH_SHUTDOWN && q.fsm == SDS_IDLE
      |=> q.busy && q.idx == `SDS_SHUTDOWN_INDEX && q.fsm == SDS_WRITE;
  endproperty
  a_launch: assert property (p_launch) else $error("shutdown launch did not start at step 25");

  property p_step25;
    q.fsm == SDS_WRITE && q.idx == 6'h19 |=> q.bank[SLOT_LINE][7:0] == 8'h77 && q.wait_cnt == 13'h0009;
  endproperty
  a_step25: assert property (p_step25) else $error("step 25 wrong value or delay");

  property p_step26;
    q.fsm == SDS_WRITE && q.idx == 6'h1A |=> q.bank[SLOT_PHONES][7:0] == 8'h77;
  endproperty
  a_step26: assert property (p_step26) else $error("step 26 wrong phones value");

  property p_step29;
    q.fsm == SDS_WRITE && q.idx == 6'h1D |=> q.bank[SLOT_SERVO][3:0] == 4'h0;
  endproperty
  a_step29: assert property (p_step29) else $error("servo channels still enabled");

  property p_step30;
    q.fsm == SDS_WRITE && q.idx == 6'h1E |=> !power_ctrl.charge_pump_enable;
  endproperty
  a_step30: assert property (p_step30) else $error("charge pump still enabled");

  property p_step36;
    q.fsm == SDS_WRITE && q.idx == 6'h24 |=> q.fsm == SDS_WAIT && q.wait_cnt == 13'h1008;
  endproperty
  a_step36: assert property (p_step36) else $error("step 36 wait not 256.5ms");

  property p_step37;
    q.fsm == SDS_WRITE && q.idx == 6'h25 |=> q.fsm == SDS_WAIT && q.wait_cnt == 13'h0208;
  endproperty
  a_step37: assert property (p_step37) else $error("step 37 wait not 32.5ms");

  property p_eos;
    q.fsm == SDS_WRITE && q.idx == LAST_STEP |=> q.fsm == SDS_IDLE && !q.busy && q.bank[SLOT_BIAS][1:0] == 2'b00;
  endproperty
  a_eos: assert property (p_eos) else $error("sequence did not stop at end step");

  property p_busy;
    (q.busy == (q.fsm != SDS_IDLE)) and ($fell(q.busy) |-> $past(q.fsm) == SDS_WRITE || $past(apb_wr));
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag disagrees with sequencer");

  property p_por_hold;
    @(posedge pclk) disable iff (!presetn) !por_ok |=> q.fsm == SDS_IDLE && !q.busy && q.bank == RST.bank;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("logic not held during power-on reset");

endmodule : sds_top
`default_nettype wire

// ==== tb/sds_host.sv ====
// Host model driving the register bus and the supply monitors
`timescale 1ns/1ns
`default_nettype none
module sds_host (
  // Clock
  input wire logic pclk,
  // Bus master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [9:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Supplies
  output logic analog_supply_ok,
  output logic core_supply_ok
);
  // Idle bus, supplies up from the start
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0000_0000;
    analog_supply_ok = 1'b1;
    core_supply_ok = 1'b1;
  end

  // One transfer, held until pready is seen high
  task xfer(input logic wr, input logic [7:0] idx, input logic [15:0] data, output logic [31:0] rdata,
            output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, data};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench watchdog ends this wait
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata; // Stale data does not linger
  endtask : xfer

  // Change the supply levels
  task supply(input logic a, input logic c);
    @(posedge pclk);
    analog_supply_ok <= a;
    core_supply_ok <= c;
  endtask : supply
endmodule : sds_host
`default_nettype wire

// ==== tb/tb_top.sv ====
// Testbench for the shutdown sequencer and power-on reset
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import sds_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, por_rel, asup, csup, err;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  sds_power_t pc, prev_pc, e;
  sds_power_t pcq[$];
  int tq[$];
  int cyc, busy_cyc, error_cnt, n_tests, t0, n;
  logic [7:0] ridx [10] = '{8'h5A, 8'h5E, 8'h43, 8'h62, 8'h12, 8'h16, 8'h0E, 8'h0F, 8'h04, 8'h05};
  logic [15:0] rinit [10] = '{16'h12FF, 16'h00FF, 16'h000F, 16'h0001, 16'h000C, 16'h0002, 16'h0003,
                              16'h0003, 16'h001B, 16'h0147};
  logic [15:0] rpost [10] = '{16'h1200, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                              16'h0000, 16'h0018, 16'h0100};

  // Design with a short tick for simulation
  sds_top #(.TICK_CYCLES(4)) sds_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analog_supply_ok(asup), .core_supply_ok(csup), .sequencer_busy_flag(busy), .por_released(por_rel),
    .power_ctrl(pc));
  sds_host sds_host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog_supply_ok(asup),
    .core_supply_ok(csup));

  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Log enable changes and busy time
  always @(posedge pclk)
  begin
    cyc++;
    if (busy === 1'b1)
    begin
      busy_cyc++;
      if (pc !== prev_pc)
      begin
        pcq.push_back(pc);
        tq.push_back(cyc);
      end
    end
    prev_pc = pc;
  end

  // Compare and count
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Verdict and end of run
  task summarize();
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  // Bounded wait for power-on reset release
  task wait_por();
    n = 0;
    while (por_rel !== 1'b1 && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_por

  // Watchdog
  initial
  begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    summarize();
  end

  // Main sequence
  initial
  begin
    presetn = 1'b0;
    cyc = 0;
    busy_cyc = 0;
    error_cnt = 0;
    n_tests = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t0 = cyc;
    sds_host_i.xfer(1'b1, 8'h04, 16'h0001, rd, err);
    chk(err, 1);
    wait_por();
    chk((cyc - t0) >= 950 && (cyc - t0) <= 960, 1);
    sds_host_i.xfer(1'b0, 8'h04, 16'h0000, rd, err);
    chk({err, rd}, 0);
    sds_host_i.xfer(1'b0, 8'h01, 16'h0000, rd, err);
    chk({err, rd}, {1'b1, 32'h0000_0000});
    // Leave the outputs as a start-up would
    for (int i = 0; i < 10; i++)
      sds_host_i.xfer(1'b1, ridx[i], rinit[i], rd, err);
    for (int i = 0; i < 10; i++)
    begin
      sds_host_i.xfer(1'b0, ridx[i], 16'h0000, rd, err);
      chk({err, rd}, {17'h0_0000, rinit[i]});
    end
    e = {8'hFF, 8'hFF, 4'hF, 4'b1111, 2'b11, 2'b11, 3'b111, 2'b11, 1'b0};
    chk(pc, e);
    // One write launches the shutdown
    sds_host_i.xfer(1'b1, 8'h6F, 16'h0119, rd, err);
    chk(err, 0);
    repeat (2) @(posedge pclk);
    chk(busy, 1);
    sds_host_i.xfer(1'b0, 8'h70, 16'h0000, rd, err);
    chk({rd[13:8], rd[0]}, {6'h19, 1'b1});
    n = 0;
    while (busy !== 1'b0 && n < 25000)
    begin
      @(posedge pclk);
      n++;
    end
    chk(busy_cyc >= 18870 && busy_cyc <= 18990, 1);
    chk(pcq.size(), 13);
    if (pcq.size() == 13)
    begin
      for (int k = 0; k < 13; k++)
      begin
        case (k)
          0: e.line_ctrl = 8'h77;
          1: e.phones_ctrl = 8'h77;
          2: e.phones_ctrl = 8'h00;
          3: e.line_ctrl = 8'h00;
          4: e.offset_servo_channel_enable = 4'h0;
          5: e.charge_pump_enable = 1'b0;
          6: {e.left_converter_enable, e.right_converter_enable} = 2'b00;
          7: e.processing_clock_enable = 1'b0;
          8: e.phones_gain_amp_enable = 2'b00;
          9: e.line_gain_amp_enable = 2'b00;
          10: e.bias_enable = 1'b0;
          11: e.midrail_reference_enable = 1'b0;
          default: {e.midrail_buffer_enable, e.midrail_resistor_select} = 3'b000;
        endcase
        chk(pcq[k], e);
        if (k > 0 && k < 12)
          chk((tq[k] - tq[k-1]) >= 34 && (tq[k] - tq[k-1]) <= 42, 1);
        if (k == 12)
          chk((tq[k] - tq[k-1]) >= 18488 && (tq[k] - tq[k-1]) <= 18512, 1);
      end
    end
    for (int i = 0; i < 10; i++)
    begin
      sds_host_i.xfer(1'b0, ridx[i], 16'h0000, rd, err);
      chk({err, rd}, {17'h0_0000, rpost[i]});
    end
    sds_host_i.xfer(1'b0, 8'h70, 16'h0000, rd, err);
    chk(rd[0], 0);
    // Supply loss re-enters power-on reset
    sds_host_i.supply(1'b0, 1'b1);
    repeat (5) @(posedge pclk);
    chk(por_rel, 0);
    sds_host_i.xfer(1'b1, 8'h04, 16'h0001, rd, err);
    chk(err, 1);
    sds_host_i.supply(1'b1, 1'b1);
    wait_por();
    sds_host_i.xfer(1'b0, 8'h04, 16'h0000, rd, err);
    chk({err, rd}, 0);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
